// ===== design/dpw_counter.sv
/*
 * One pulse width down-counter channel, 8 or 16 bits wide.
 * Assumes tick_i and period_i are single-cycle pulses on ref_clk_i.
 */
`default_nettype none

module dpw_counter #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire logic         enable_i,
    input  wire logic         tick_i,
    input  wire logic         period_i,
    input  wire logic [W-1:0] reload_i,
    input  wire logic         full_i,
    output logic              out_o,
    output logic              armed_o
);
    import dpw_pkg::*;

    localparam logic [W-1:0] CNT_ONE = W'(1);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         out_reg;
    logic         out_next;
    logic         armed_reg;
    logic         armed_next;
    logic         full_reg;
    logic         full_next;

    always_comb begin
        cnt_next   = cnt_reg;
        out_next   = out_reg;
        armed_next = armed_reg;
        full_next  = full_reg;
        if (!enable_i) begin
            cnt_next   = '0;
            out_next   = 1'b0;
            armed_next = 1'b0;
            full_next  = 1'b0;
        end else if (period_i) begin
            cnt_next   = reload_i;
            out_next   = (reload_i != '0);
            armed_next = 1'b1;
            full_next  = full_i;
        end else if (armed_reg && tick_i && (cnt_reg != '0) && !full_reg) begin
            cnt_next = cnt_reg - CNT_ONE;
            out_next = (cnt_reg != CNT_ONE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg   <= '0;
            out_reg   <= 1'b0;
            armed_reg <= 1'b0;
            full_reg  <= 1'b0;
        end else if (ce_i) begin
            cnt_reg   <= cnt_next;
            out_reg   <= out_next;
            armed_reg <= armed_next;
            full_reg  <= full_next;
        end
    end

    assign out_o   = out_reg;
    assign armed_o = armed_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_reload_nz;
        ce_i && enable_i && period_i && (reload_i != '0);
    endsequence

    sequence s_step;
        ce_i && enable_i && !period_i && armed_reg && tick_i && !full_reg && (cnt_reg > CNT_ONE);
    endsequence

    AST_RELOAD_HIGH: assert property (s_reload_nz |=> out_reg && armed_reg && (cnt_reg == $past(reload_i)))
        else $error("reload did not raise output");
    AST_COUNT_DOWN: assert property (s_step |=> out_reg && (cnt_reg == $past(cnt_reg) - CNT_ONE))
        else $error("counter did not step down by one");
    AST_ZERO_LOW: assert property (ce_i && enable_i && !period_i && armed_reg && (cnt_reg == '0)
                                   |=> !out_reg && (cnt_reg == '0))
        else $error("counter at zero did not halt low");
    AST_WAIT_ARM: assert property (ce_i && !armed_reg && !(enable_i && period_i) |=> !out_reg && !armed_reg)
        else $error("output started before a period pulse");
    AST_FULL_HIGH: assert property (ce_i && enable_i && armed_reg && full_reg && !period_i
                                    |=> out_reg && $stable(cnt_reg))
        else $error("full width value did not hold output high");

endmodule : dpw_counter

`default_nettype wire

// ===== design/dpw_sync.sv
/*
 * Two-flop synchroniser for a group of independent level inputs.
 * Assumes every bit is a slow level from outside the ref_clk_i domain.
 */
`default_nettype none

module dpw_sync #(
    parameter int unsigned W = 4
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rstn_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    import dpw_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule : dpw_sync

`default_nettype wire

// ===== design/dpw_top.sv
/*
 * One pulse width modulator module: a pair of 8-bit channels that may be
 * joined into one 16-bit channel, with its APB register slave.
 * Assumes clock and period sources arrive as pins from outside the
 * ref_clk_i domain and that source selection and output multiplexing are
 * fixed hardware options (parameters).
 */
// Local design decisions: the address map and the APB register port.
`default_nettype none

module dpw_top #(
    parameter int unsigned PAIR_IDX    = 0,
    parameter int unsigned CLK_SRC_SEL = 0,
    parameter int unsigned PER_SRC_SEL = 1,
    parameter bit          OUT_MUX_SEL = 1'b1
) (
    input  wire logic                           ref_clk_i,
    input  wire logic                           rstn_i,
    input  wire logic                           ce_i,
    input  wire logic [dpw_pkg::ADDR_W-1:0]     paddr_i,
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [dpw_pkg::DATA_W-1:0]     pwdata_i,
    output logic      [dpw_pkg::DATA_W-1:0]     prdata_o,
    output logic                                pready_o,
    output logic                                pslverr_o,
    input  wire logic [dpw_pkg::SRC_NUM-1:0]    src_i,
    input  wire logic                           alt_func_i,
    output logic                                lower_channel_o,
    output logic                                upper_channel_o
);
    import dpw_pkg::*;

    localparam int unsigned LO_DLY = (2 * PAIR_IDX) % EMI_MOD;
    localparam int unsigned UP_DLY = (2 * PAIR_IDX + 1) % EMI_MOD;

    // source pins, edge detection
    logic [SRC_NUM-1:0] src_sync;
    logic [SRC_NUM-1:0] src_prev_reg;
    logic               tick;
    logic               per_raw;

    dpw_sync #(
        .W         (SRC_NUM)
    ) u_src_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .d_i       (src_i),
        .q_o       (src_sync)
    );

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_prev_reg <= '0;
        end else if (ce_i) begin
            src_prev_reg <= src_sync;
        end
    end

    // both channels see one clock source and one period source
    assign tick    = src_sync[CLK_SRC_SEL] & ~src_prev_reg[CLK_SRC_SEL];
    assign per_raw = src_sync[PER_SRC_SEL] & ~src_prev_reg[PER_SRC_SEL];

    // staggered period start per channel spreads switching edges
    logic [1:0] per_ch;

    for (genvar c = 0; c < 2; c++) begin : g_dly
        localparam int unsigned D = (c == 0) ? LO_DLY : UP_DLY;
        logic [DLY_STAGES-1:0] dly_reg;
        logic [DLY_STAGES-1:0] dly_next;

        always_comb begin
            dly_next = {dly_reg[DLY_STAGES-2:0], per_raw};
        end

        always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                dly_reg <= '0;
            end else if (ce_i) begin
                dly_reg <= dly_next;
            end
        end

        if (D == 0) begin : g_direct
            assign per_ch[c] = per_raw;
        end else begin : g_tap
            assign per_ch[c] = dly_reg[D-1];
        end
    end

    // register state
    logic [BYTE_W-1:0] lo_reg;
    logic [BYTE_W-1:0] lo_next;
    logic [BYTE_W-1:0] hi_reg;
    logic [BYTE_W-1:0] hi_next;
    logic [BYTE_W-1:0] cmt_lo_reg;
    logic [BYTE_W-1:0] cmt_lo_next;
    logic [BYTE_W-1:0] cmt_hi_reg;
    logic [BYTE_W-1:0] cmt_hi_next;
    logic              pend_hi_reg;
    logic              pend_hi_next;
    logic              wide_reg;
    logic              wide_next;
    logic              enable_reg;
    logic              enable_next;

    // apb slave state
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;
    logic              pready_next;
    logic              pslverr_reg;
    logic              pslverr_next;

    logic              setup;
    logic              done;
    logic              wr;
    logic              mapped;
    logic [ST_W-1:0]   status;

    logic              lo_out;
    logic              up_out;
    logic              lo_arm;
    logic              up_arm;

    assign setup  = psel_i & ~penable_i;
    assign done   = psel_i & penable_i & pready_reg;
    assign wr     = done & pwrite_i;
    assign mapped = (paddr_i == OFS_LOWER) || (paddr_i == OFS_UPPER) || (paddr_i == OFS_MODE)
                    || (paddr_i == OFS_ENABLE) || (paddr_i == OFS_STATUS);

    always_comb begin
        status               = '0;
        status[ST_LOWER_OUT] = lower_channel_o;
        status[ST_UPPER_OUT] = upper_channel_o;
        status[ST_ENABLE]    = enable_reg;
        status[ST_WIDE]      = wide_reg;
        status[ST_LOWER_ARM] = lo_arm;
        status[ST_UPPER_ARM] = up_arm;
        status[ST_PEND_HI]   = pend_hi_reg;
    end

    // one wait-free access: answer is set up during the setup cycle
    always_comb begin
        pready_next  = setup;
        pslverr_next = setup & ~mapped;
        prdata_next  = done ? '0 : prdata_reg;
        if (setup && !pwrite_i) begin
            unique case (paddr_i)
                OFS_ENABLE: prdata_next = {{(DATA_W-1){1'b0}}, enable_reg};
                OFS_STATUS: prdata_next = {{(DATA_W-ST_W){1'b0}}, status};
                default:    prdata_next = '0;
            endcase
        end
    end

    always_comb begin
        lo_next      = lo_reg;
        hi_next      = hi_reg;
        wide_next    = wide_reg;
        enable_next  = enable_reg;
        pend_hi_next = pend_hi_reg & wide_reg;
        if (wr) begin
            unique case (paddr_i)
                OFS_LOWER: begin
                    lo_next      = pwdata_i[BYTE_W-1:0];
                    pend_hi_next = wide_reg;
                end
                OFS_UPPER: begin
                    hi_next      = pwdata_i[BYTE_W-1:0];
                    pend_hi_next = 1'b0;
                end
                OFS_MODE: begin
                    // mode is latched only while the module is disabled
                    if (!enable_reg) begin
                        wide_next = pwdata_i[PAIR_IDX];
                    end
                end
                OFS_ENABLE: enable_next = pwdata_i[EN_BIT];
                default:    enable_next = enable_reg;
            endcase
        end
        // a half-written wide value is never committed to the counter
        cmt_lo_next = pend_hi_next ? cmt_lo_reg : lo_next;
        cmt_hi_next = pend_hi_next ? cmt_hi_reg : hi_next;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lo_reg      <= PW_RESET;
            hi_reg      <= PW_RESET;
            cmt_lo_reg  <= PW_RESET;
            cmt_hi_reg  <= PW_RESET;
            pend_hi_reg <= 1'b0;
            wide_reg    <= MODE_RESET[0];
            enable_reg  <= EN_RESET;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce_i) begin
            lo_reg      <= lo_next;
            hi_reg      <= hi_next;
            cmt_lo_reg  <= cmt_lo_next;
            cmt_hi_reg  <= cmt_hi_next;
            pend_hi_reg <= pend_hi_next;
            wide_reg    <= wide_next;
            enable_reg  <= enable_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;

    // channels; in wide mode the upper counter carries all 16 bits
    logic [WIDE_W-1:0] up_reload;
    logic              up_full;

    assign up_reload = wide_reg ? {cmt_hi_reg, cmt_lo_reg} : {BYTE_ZERO, cmt_hi_reg};
    assign up_full   = wide_reg ? ({cmt_hi_reg, cmt_lo_reg} == PW_FULL16) : (cmt_hi_reg == PW_FULL8);

    dpw_counter #(
        .W         (BYTE_W)
    ) u_lower (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .enable_i  (enable_reg & ~wide_reg),
        .tick_i    (tick),
        .period_i  (per_ch[0]),
        .reload_i  (cmt_lo_reg),
        .full_i    (cmt_lo_reg == PW_FULL8),
        .out_o     (lo_out),
        .armed_o   (lo_arm)
    );

    dpw_counter #(
        .W         (WIDE_W)
    ) u_upper (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .enable_i  (enable_reg),
        .tick_i    (tick),
        .period_i  (per_ch[1]),
        .reload_i  (up_reload),
        .full_i    (up_full),
        .out_o     (up_out),
        .armed_o   (up_arm)
    );

    // pins: gated by enable (upper pin only when OUT_MUX_SEL) so standby drops them one edge after the write
    logic lo_pin_reg;
    logic lo_pin_next;
    logic up_pin_reg;
    logic up_pin_next;

    always_comb begin
        lo_pin_next = enable_reg & ~wide_reg & lo_out;
        up_pin_next = OUT_MUX_SEL ? (enable_reg & up_out) : alt_func_i;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lo_pin_reg <= 1'b0;
            up_pin_reg <= 1'b0;
        end else if (ce_i) begin
            lo_pin_reg <= lo_pin_next;
            up_pin_reg <= up_pin_next;
        end
    end

    assign lower_channel_o = lo_pin_reg;
    assign upper_channel_o = up_pin_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_read_pw;
        done && !pwrite_i && ((paddr_i == OFS_LOWER) || (paddr_i == OFS_UPPER) || (paddr_i == OFS_MODE));
    endsequence

    sequence s_mode_write;
        ce_i && wr && (paddr_i == OFS_MODE) && !enable_reg;
    endsequence

    AST_STANDBY_LOW: assert property (ce_i && !enable_reg |=> !lower_channel_o
                                      && (!OUT_MUX_SEL || !upper_channel_o))
        else $error("output not low in standby");
    AST_WIDE_LOWER_IDLE: assert property (ce_i && wide_reg |=> !lower_channel_o)
        else $error("lower output active in wide mode");
    AST_READ_ZERO: assert property (s_read_pw |-> (prdata_o == '0))
        else $error("write-only register returned data");
    AST_MODE_HELD: assert property (enable_reg |=> $stable(wide_reg))
        else $error("width mode changed while enabled");
    AST_MODE_WRITE: assert property (s_mode_write |=> (wide_reg == $past(pwdata_i[PAIR_IDX])))
        else $error("mode bit not taken");
    AST_PAIR_LOCK: assert property (pend_hi_reg && !(wr && (paddr_i == OFS_UPPER))
                                    |=> $stable(cmt_lo_reg) && $stable(cmt_hi_reg))
        else $error("partial wide value committed");
    AST_EMI_DELAY: assert property (disable iff (!rstn_i || !ce_i)
                                    per_ch[1] |-> $past(per_raw, UP_DLY))
        else $error("upper period start delay wrong");
    AST_MUX_ALT: assert property (ce_i && !OUT_MUX_SEL |=> (upper_channel_o == $past(alt_func_i)))
        else $error("output multiplexer not following alternate source");
    AST_APB_ANSWER: assert property (ce_i && setup |=> pready_o && (pslverr_o == !$past(mapped)))
        else $error("apb answer not given in access cycle");

endmodule : dpw_top

`default_nettype wire

// ===== include/dpw_pkg.sv
/*
 * Constants for the dual pulse width modulator pair: register offsets,
 * field positions, reset values and the fixed figures of the counters.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
`default_nettype none

package dpw_pkg;

    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned WIDE_W      = 16;
    localparam int unsigned MODE_BITS   = 6;
    localparam int unsigned SRC_NUM     = 4;

    localparam logic [ADDR_W-1:0] OFS_LOWER  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_UPPER  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    localparam logic [BYTE_W-1:0]    PW_RESET    = 8'h00;
    localparam logic [MODE_BITS-1:0] MODE_RESET  = 6'h00;
    localparam logic                 EN_RESET    = 1'b0;
    localparam logic [BYTE_W-1:0]    PW_FULL8    = 8'hFF;
    localparam logic [WIDE_W-1:0]    PW_FULL16   = 16'hFFFF;
    localparam logic [BYTE_W-1:0]    BYTE_ZERO   = 8'h00;

    localparam int unsigned EN_BIT        = 0;
    localparam int unsigned ST_LOWER_OUT  = 0;
    localparam int unsigned ST_UPPER_OUT  = 1;
    localparam int unsigned ST_ENABLE     = 2;
    localparam int unsigned ST_WIDE       = 3;
    localparam int unsigned ST_LOWER_ARM  = 4;
    localparam int unsigned ST_UPPER_ARM  = 5;
    localparam int unsigned ST_PEND_HI    = 6;
    localparam int unsigned ST_W          = 7;

    localparam int unsigned EMI_MOD       = 4;
    localparam int unsigned DLY_STAGES    = 3;

endpackage : dpw_pkg

`default_nettype wire

// ===== tb/dpw_load_model.sv
/*
 * Load on one channel pin: counts the cycles the pin is high between two
 * period marks and records the cycle of its latest rising edge.
 * Assumes mark_i is the period source pin as the bench drives it.
 */
`default_nettype none

module dpw_load_model (
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic wave_i,
    input  wire logic mark_i,
    output var  int   hi_cnt_o,
    output var  int   rise_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int   cyc;
    int   hi_run;
    logic wave_q;
    logic mark_q;

    // a whole window is latched at each mark so the bench never sees a partial count
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc      <= 0;
            hi_run   <= 0;
            hi_cnt_o <= 0;
            rise_o   <= 0;
            wave_q   <= 1'b0;
            mark_q   <= 1'b0;
        end else begin
            cyc    <= cyc + 1;
            wave_q <= wave_i;
            mark_q <= mark_i;
            if (wave_i && !wave_q) begin
                rise_o <= cyc;
            end
            if (mark_i && !mark_q) begin
                hi_cnt_o <= hi_run;
                hi_run   <= int'(wave_i);
            end else begin
                hi_run <= hi_run + int'(wave_i);
            end
        end
    end
endmodule : dpw_load_model

`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench for two modulator pairs, the second with OUT_MUX_SEL off:
 * APB master, tick and period source pins, one load model per channel pin of the first.
 * Assumes PAIR_IDX 0, tick on src_i[0], period on src_i[1].
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dpw_pkg::*;

    logic        ref_clk_i;
    logic        rstn_i;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  src = 4'h0;
    logic        alt = 1'b0;
    logic        alt_q = 1'b0;
    logic        alt_pin;
    logic        low_pin;
    logic        up_pin;
    int          failures;
    int          check_count;
    int          per_ticks;
    int          pc = 0;
    bit          per_run;

    dpw_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .src_i(src), .alt_func_i(alt), .lower_channel_o(low_pin),
        .upper_channel_o(up_pin));
    dpw_load_model l (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wave_i(low_pin), .mark_i(src[1]),
        .hi_cnt_o(), .rise_o());
    dpw_load_model u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wave_i(up_pin), .mark_i(src[1]),
        .hi_cnt_o(), .rise_o());
    // second pair with the shared pin handed to the other module's signal
    dpw_top #(.OUT_MUX_SEL(1'b0)) DUT_MUX (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(), .pready_o(),
        .pslverr_o(), .src_i(src), .alt_func_i(alt), .lower_channel_o(), .upper_channel_o(alt_pin));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // one tick every two cycles, a period every per_ticks ticks
    always @(posedge ref_clk_i) begin
        src[0]   <= ~src[0];
        src[3:2] <= 2'($urandom);
        alt      <= 1'($urandom);
        alt_q    <= alt;
        pc       <= (pc >= 2 * per_ticks - 1) ? 0 : pc + 1;
        src[1]   <= per_run && (pc < 2);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] near(input int h, input int n);
        return 32'(h >= 2 * n - 2 && h <= 2 * n + 2);
    endfunction : near

    task automatic marks(input int k);
        repeat (k) @(posedge src[1]);
        repeat (20) @(posedge ref_clk_i);
    endtask : marks

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        failures++;
        end_sim();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        int          n1;
        int          n2;
        rstn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        per_ticks = 256;
        per_run = 1'b0;
        failures = 0;
        check_count = 0;
        void'($urandom(32'h86E28012));
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(negedge ref_clk_i);
        chk(32'({low_pin, up_pin, pready}), 32'h0);
        apb(1'b0, OFS_LOWER, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(32'(e), 32'h1);
        $display("test reset done");
        repeat (8) begin
            @(negedge ref_clk_i);
            chk(32'(alt_pin), 32'(alt_q));
        end
        apb(1'b1, OFS_ENABLE, 32'h1, r, e);
        apb(1'b1, OFS_LOWER, 32'h10, r, e);
        repeat (40) @(posedge ref_clk_i);
        chk(32'(low_pin), 32'h0);
        per_run <= 1'b1;
        $display("test first period done");
        for (int i = 0; i < 5; i++) begin
            n1 = (i == 0) ? 1 : 1 + int'($urandom % 254);
            n2 = (i == 0) ? 254 : 1 + int'($urandom % 254);
            apb(1'b1, OFS_LOWER, 32'(n1), r, e);
            apb(1'b1, OFS_UPPER, 32'(n2), r, e);
            marks(3);
            chk(near(l.hi_cnt_o, n1), 32'h1);
            chk(near(u.hi_cnt_o, n2), 32'h1);
            chk(32'(u.rise_o - l.rise_o), 32'h1);
        end
        apb(1'b1, OFS_LOWER, 32'h00, r, e);
        apb(1'b1, OFS_UPPER, 32'hFF, r, e);
        marks(3);
        chk(32'(l.hi_cnt_o), 32'h0);
        chk(32'(u.hi_cnt_o), 32'(2 * per_ticks));
        $display("test narrow widths done");
        apb(1'b1, OFS_MODE, 32'h1, r, e);
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk(32'(r[ST_WIDE]), 32'h0);
        apb(1'b1, OFS_ENABLE, 32'h0, r, e);
        apb(1'b1, OFS_MODE, 32'h1, r, e);
        apb(1'b1, OFS_ENABLE, 32'h1, r, e);
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk(32'(r[ST_WIDE]), 32'h1);
        apb(1'b0, OFS_MODE, 32'h0, r, e);
        chk(r, 32'h0);
        $display("test mode select done");
        per_ticks <= 320;
        apb(1'b1, OFS_LOWER, 32'h05, r, e);
        apb(1'b1, OFS_UPPER, 32'h01, r, e);
        marks(3);
        chk(32'(l.hi_cnt_o), 32'h0);
        chk(near(u.hi_cnt_o, 261), 32'h1);
        apb(1'b1, OFS_LOWER, 32'h40, r, e);
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        chk(32'(r[ST_PEND_HI]), 32'h1);
        marks(3);
        chk(near(u.hi_cnt_o, 261), 32'h1);
        apb(1'b1, OFS_UPPER, 32'h00, r, e);
        marks(3);
        chk(near(u.hi_cnt_o, 64), 32'h1);
        apb(1'b1, OFS_LOWER, 32'hFF, r, e);
        apb(1'b1, OFS_UPPER, 32'hFF, r, e);
        marks(3);
        chk(32'(u.hi_cnt_o), 32'(2 * per_ticks));
        $display("test wide mode done");
        apb(1'b1, OFS_ENABLE, 32'h0, r, e);
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(32'({low_pin, up_pin}), 32'h0);
        $display("test disable done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
